// File: lcad_core.sv
// host-port address decode: channels 2 to 4, input bytes, bidir window
// assumes the host-cycle port is driven by lpc cycle logic on clk
//
// Function
// - ch2/ch4 write loads input byte; bit2 picks data/command, output/status
// - ch3 enable on means every host address is compared with ch3 base
// - ch3 input/output/status match takes base bit0 as zero, ignores bit2
// - bidir match inverts base bit4, ignores bits 3..0; they pick register
// - bidir enable bit gates host access to the bidir window, not slave access
// - offset zero: host writes host_to_slave, reads slave_to_host mailbox
// - offsets one to fifteen select bidir bytes both ways
// - ch3 address fields are slave writable and reset to zero
// - ch4 base bit2 takes no part in matching
// - input bytes are eight bits, slave reads only, host writes only
// - host write byte lands in the register its address selected
// - each input byte write captures address bit2 into command/data bit
// - input bytes have no reset value
// - command/data bit reads zero for data, one for command
// - input buffer full sets on host write, clears on slave read
`default_nettype none

module lcad_core (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire lcad_pkg::lcad_hreq_t hreq,
  output lcad_pkg::lcad_hrsp_t      hrsp,
  output logic                      irq
);

  // ==========================================================
  // helpers
  function automatic logic fn_match(input logic [15:0] base,
                                    input logic [15:0] addr,
                                    input logic [15:0] mask);
    fn_match = ((base ^ addr) & mask) == 16'h0000;
  endfunction

  function automatic logic fn_mapped(input logic [7:0] a);
    logic hit;
    hit = (a == lcad_pkg::OFF_CH2_BASE) || (a == lcad_pkg::OFF_CH3_HIGH) ||
          (a == lcad_pkg::OFF_CH3_LOW)  || (a == lcad_pkg::OFF_CH4_HIGH) ||
          (a == lcad_pkg::OFF_CH4_LOW)  || (a == lcad_pkg::OFF_ENABLE)   ||
          (a == lcad_pkg::OFF_CH_STATUS) ||
          (a == lcad_pkg::OFF_IRQ_STAT) || (a == lcad_pkg::OFF_IRQ_MASK) ||
          (a[7:6] == lcad_pkg::BIDIR_PAGE);
    for (int k = 0; k < 3; k++) begin
      hit = hit || (a == lcad_pkg::OFF_IN_BYTE[k]) ||
            (a == lcad_pkg::OFF_OUT_BYTE[k]);
    end
    fn_mapped = hit;
  endfunction

  lcad_pkg::lcad_state_t st;
  lcad_pkg::lcad_state_t next_st;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // host address decode
  logic [15:0] ch3_base;
  logic [15:0] bidir_base;
  logic [2:0]  chan_match;
  logic        bidir_match;
  logic [2:0]  chan_hit;
  logic        bidir_hit;
  logic [3:0]  bidir_idx;

  always_comb begin
    ch3_base   = {st.ch3_high, st.ch3_low[7:1], 1'b0};
    bidir_base = {st.ch3_high, st.ch3_low[7:5], ~st.ch3_low[4],
                  st.ch3_low[3:0]};
    chan_match[0] = st.enable[0] &&
                    fn_match(st.ch2_base, hreq.addr, lcad_pkg::MASK_CHAN);
    chan_match[1] = st.enable[1] &&
                    fn_match(ch3_base, hreq.addr, lcad_pkg::MASK_CHAN);
    chan_match[2] = st.enable[2] &&
                    fn_match({st.ch4_high, st.ch4_low}, hreq.addr,
                             lcad_pkg::MASK_CHAN);
    bidir_match   = st.enable[1] && st.ch3_low[lcad_pkg::BIT_BIDIR_EN] &&
                    fn_match(bidir_base, hreq.addr,
                             lcad_pkg::MASK_BIDIR);
    // overlapping bases are a software fault; lowest channel wins anyway
    chan_hit[0] = chan_match[0];
    chan_hit[1] = chan_match[1] && !chan_match[0];
    chan_hit[2] = chan_match[2] && !(|chan_match[1:0]);
    bidir_hit   = bidir_match && !(|chan_match);
    bidir_idx   = hreq.addr[3:0];
  end

  // ==========================================================
  // apb slave: zero wait states, read data latched in setup phase
  logic apb_setup;
  logic apb_acc;
  logic apb_wr;
  logic apb_rd_edge;
  logic [3:0] apb_idx;

  assign apb_setup   = psel && !penable;
  assign apb_acc     = psel && penable;
  assign apb_wr      = apb_acc && pwrite && fn_mapped(paddr);
  // the read is done at the setup edge so prdata and the clear agree
  assign apb_rd_edge = apb_setup && !pwrite;
  assign apb_idx     = paddr[5:2];
  assign pready      = 1'b1;
  assign pslverr     = apb_acc && !fn_mapped(paddr);

  always_comb begin
    next_st           = st;
    next_st.hrsp      = '0;
    // ---------------- slave register reads
    if (apb_setup) begin
      next_st.prdata = 32'h0000_0000;
      case (paddr)
        lcad_pkg::OFF_CH2_BASE:  next_st.prdata[15:0] = st.ch2_base;
        lcad_pkg::OFF_CH3_HIGH:  next_st.prdata[7:0]  = st.ch3_high;
        lcad_pkg::OFF_CH3_LOW:   next_st.prdata[7:0]  = st.ch3_low;
        lcad_pkg::OFF_CH4_HIGH:  next_st.prdata[7:0]  = st.ch4_high;
        lcad_pkg::OFF_CH4_LOW:   next_st.prdata[7:0]  = st.ch4_low;
        lcad_pkg::OFF_ENABLE:    next_st.prdata[2:0]  = st.enable;
        lcad_pkg::OFF_CH_STATUS: begin
          next_st.prdata[2:0] = st.ibf;
          next_st.prdata[lcad_pkg::STS_CD_LSB +: 3] = st.cmd_data;
        end
        lcad_pkg::OFF_IRQ_STAT:  next_st.prdata[3:0]  = st.irq_stat;
        lcad_pkg::OFF_IRQ_MASK:  next_st.prdata[3:0]  = st.irq_mask;
        default: begin
          if (paddr[7:6] == lcad_pkg::BIDIR_PAGE) begin
            next_st.prdata[7:0] = st.bidir[apb_idx];
          end
          for (int k = 0; k < 3; k++) begin
            if (paddr == lcad_pkg::OFF_IN_BYTE[k]) begin
              next_st.prdata[7:0] = st.in_byte[k];
            end
            if (paddr == lcad_pkg::OFF_OUT_BYTE[k]) begin
              next_st.prdata[7:0] = st.out_byte[k];
            end
          end
        end
      endcase
    end
    // slave read of an input byte empties the buffer
    for (int k = 0; k < 3; k++) begin
      if (apb_rd_edge && paddr == lcad_pkg::OFF_IN_BYTE[k]) begin
        next_st.ibf[k] = 1'b0;
      end
    end
    // ---------------- slave register writes
    if (apb_wr) begin
      case (paddr)
        lcad_pkg::OFF_CH2_BASE:  next_st.ch2_base = pwdata[15:0];
        lcad_pkg::OFF_CH3_HIGH:  next_st.ch3_high = pwdata[7:0];
        lcad_pkg::OFF_CH3_LOW:   next_st.ch3_low  = pwdata[7:0];
        lcad_pkg::OFF_CH4_HIGH:  next_st.ch4_high = pwdata[7:0];
        lcad_pkg::OFF_CH4_LOW:   next_st.ch4_low  = pwdata[7:0];
        lcad_pkg::OFF_ENABLE:    next_st.enable   = pwdata[2:0];
        lcad_pkg::OFF_IRQ_STAT:
          next_st.irq_stat = st.irq_stat & ~pwdata[3:0];
        lcad_pkg::OFF_IRQ_MASK:  next_st.irq_mask = pwdata[3:0];
        default: begin
          if (paddr[7:6] == lcad_pkg::BIDIR_PAGE) begin
            if (apb_idx == 4'h0) begin
              next_st.s2h_mailbox = pwdata[7:0];
            end else begin
              next_st.bidir[apb_idx] = pwdata[7:0];
            end
          end
          for (int k = 0; k < 3; k++) begin
            if (paddr == lcad_pkg::OFF_OUT_BYTE[k]) begin
              next_st.out_byte[k] = pwdata[7:0];
            end
          end
        end
      endcase
    end
    // ---------------- host cycles; placed last so a set beats a clear
    if (hreq.valid && (|chan_hit || bidir_hit)) begin
      next_st.hrsp.claim = 1'b1;
      for (int k = 0; k < 3; k++) begin
        if (chan_hit[k] && hreq.write) begin
          next_st.in_byte[k]  = hreq.data;
          next_st.cmd_data[k] = hreq.addr[lcad_pkg::BIT_CMD_DATA];
          next_st.ibf[k]      = 1'b1;
          next_st.irq_stat[k] = 1'b1;
        end
        if (chan_hit[k] && !hreq.write) begin
          if (hreq.addr[lcad_pkg::BIT_CMD_DATA]) begin
            next_st.hrsp.data = 8'h00;
            next_st.hrsp.data[lcad_pkg::BIT_STS_CD]  = st.cmd_data[k];
            next_st.hrsp.data[lcad_pkg::BIT_STS_IBF] = st.ibf[k];
          end else begin
            next_st.hrsp.data = st.out_byte[k];
          end
        end
      end
      if (bidir_hit) begin
        if (hreq.write) begin
          // host wins a same-cycle collision with a slave write
          next_st.bidir[bidir_idx] = hreq.data;
          if (bidir_idx == 4'h0) begin
            next_st.irq_stat[lcad_pkg::IRQ_MAILBOX] = 1'b1;
          end
        end else if (bidir_idx == 4'h0) begin
          next_st.hrsp.data = st.s2h_mailbox;
        end else begin
          next_st.hrsp.data = st.bidir[bidir_idx];
        end
      end
    end
  end

  // ==========================================================
  // state register; input bytes and bidir bytes keep no reset value
  always_ff @(posedge clk) begin
    st <= next_st;
    if (!reset_n) begin
      st.ch2_base    <= lcad_pkg::RST_CH2_BASE;
      st.ch3_high    <= lcad_pkg::RST_BASE_BYTE;
      st.ch3_low     <= lcad_pkg::RST_BASE_BYTE;
      st.ch4_high    <= lcad_pkg::RST_BASE_BYTE;
      st.ch4_low     <= lcad_pkg::RST_BASE_BYTE;
      st.enable      <= '0;
      st.ibf         <= '0;
      st.cmd_data    <= '0;
      st.s2h_mailbox <= '0;
      st.irq_stat    <= '0;
      st.irq_mask    <= '0;
      st.prdata      <= '0;
      st.hrsp        <= '0;
    end
  end

  assign prdata = st.prdata;
  assign hrsp   = st.hrsp;
  assign irq    = |(st.irq_stat & st.irq_mask);

  // ==========================================================
  // checks
  sequence s_ch2_write;
    hreq.valid && hreq.write && chan_hit[0];
  endsequence

  sequence s_mbox_hit(logic wr);
    hreq.valid && bidir_hit && (hreq.write == wr) && (bidir_idx == 4'h0);
  endsequence

  a_ibf_set_write: assert property (s_ch2_write |=> st.ibf[0] && hrsp.claim)
    else $error("ibf not set after host write");

  a_cd_capture: assert property (s_ch2_write |=>
      st.cmd_data[0] == $past(hreq.addr[lcad_pkg::BIT_CMD_DATA]))
    else $error("command/data bit not captured");

  a_in_byte_store: assert property (s_ch2_write |=>
      st.in_byte[0] == $past(hreq.data))
    else $error("input byte not stored");

  a_unmatched_quiet: assert property (
      hreq.valid && !(|chan_match) && !bidir_match |=>
      !hrsp.claim && $stable(st.in_byte) && $stable(st.cmd_data))
    else $error("unmatched cycle had an effect");

  a_ch3_disabled: assert property (
      hreq.valid && !st.enable[1] && !apb_wr |=>
      $stable(st.in_byte[1]) && $stable(st.bidir))
    else $error("disabled channel 3 responded");

  a_bidir_gated: assert property (
      hreq.valid && hreq.write && !st.ch3_low[lcad_pkg::BIT_BIDIR_EN] &&
      !apb_wr |=> $stable(st.bidir))
    else $error("bidir written while disabled");

  a_mailbox_write: assert property (s_mbox_hit(1'b1) |=>
      st.bidir[0] == $past(hreq.data) && $stable(st.s2h_mailbox))
    else $error("host mailbox write wrong");

  a_mailbox_read: assert property (s_mbox_hit(1'b0) |=>
      hrsp.claim && hrsp.data == $past(st.s2h_mailbox))
    else $error("host mailbox read wrong");

  a_status_read: assert property (
      hreq.valid && !hreq.write && chan_hit[2] &&
      hreq.addr[lcad_pkg::BIT_CMD_DATA] |=>
      hrsp.data[lcad_pkg::BIT_STS_CD] == $past(st.cmd_data[2]))
    else $error("status byte command/data wrong");

  a_ibf_slave_clear: assert property (
      apb_rd_edge && paddr == lcad_pkg::OFF_IN_BYTE[1] && !hreq.valid |=>
      !st.ibf[1])
    else $error("ibf not cleared by slave read");

  a_base_reset: assert property (
      reset_n && !$past(reset_n) |->
      st.ch3_high == 8'h00 && st.ch3_low == 8'h00)
    else $error("channel 3 base not reset");

endmodule

`default_nettype wire

// File: lcad_host_model.sv
// host model: issues one host i/o cycle at a time on the host-cycle port
// assumes the core claims on the edge after valid and holds claim one cycle
`default_nettype none

module lcad_host_model (
  input  wire logic                 clk,
  output var  lcad_pkg::lcad_hreq_t hreq,
  input  wire lcad_pkg::lcad_hrsp_t hrsp
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // one cycle
  // released fields are inverted so a stale request is never trusted
  initial hreq = '0;

  task automatic cycle(input logic w, input logic [15:0] a,
                       input logic [7:0] d, output logic c,
                       output logic [7:0] q);
    @(posedge clk);
    hreq <= '{valid: 1'b1, write: w, addr: a, data: d};
    @(posedge clk);
    hreq <= '{valid: 1'b0, write: ~w, addr: ~a, data: ~d};
    @(negedge clk);
    c = hrsp.claim;
    q = hrsp.data;
  endtask
endmodule

`default_nettype wire

// File: lcad_pkg.sv
// package for the host-port channel address decode block
// assumes one 200 MHz clock shared by the bus slave and the host-cycle port
`default_nettype none

package lcad_pkg;

  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [7:0] OFF_CH2_BASE  = 8'h00;
  localparam logic [7:0] OFF_CH3_HIGH  = 8'h04;
  localparam logic [7:0] OFF_CH3_LOW   = 8'h08;
  localparam logic [7:0] OFF_CH4_HIGH  = 8'h0c;
  localparam logic [7:0] OFF_CH4_LOW   = 8'h10;
  localparam logic [7:0] OFF_ENABLE    = 8'h14;
  localparam logic [7:0] OFF_CH_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h34;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h38;
  // per channel 2, 3, 4: input byte and output byte
  localparam logic [2:0][7:0] OFF_IN_BYTE  = {8'h20, 8'h1c, 8'h18};
  localparam logic [2:0][7:0] OFF_OUT_BYTE = {8'h30, 8'h2c, 8'h28};
  // bidirectional window: paddr[7:6] == BIDIR_PAGE, index in paddr[5:2]
  localparam logic [1:0]      BIDIR_PAGE = 2'h1;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_CH2_BASE = 16'h0062;
  localparam logic [7:0]  RST_BASE_BYTE = 8'h00;

  // ==========================================================
  // field positions
  localparam int BIT_BIDIR_EN  = 0;  // in chan3 low register
  localparam int BIT_CMD_DATA  = 2;  // host address bit: 1 = command
  localparam int BIT_STS_CD    = 3;  // host status byte
  localparam int BIT_STS_IBF   = 1;  // host status byte
  localparam int STS_CD_LSB    = 4;  // slave channel status register
  localparam int IRQ_MAILBOX   = 3;  // irq bit for mailbox writes

  // match masks: one bits take part in the compare
  localparam logic [15:0] MASK_CHAN  = 16'hfffb;
  localparam logic [15:0] MASK_BIDIR = 16'hfff0;

  // ==========================================================
  // host-cycle carriers
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } lcad_hreq_t;

  typedef struct packed {
    logic       claim;
    logic [7:0] data;
  } lcad_hrsp_t;

  typedef struct packed {
    logic [15:0]      ch2_base;
    logic [7:0]       ch3_high;
    logic [7:0]       ch3_low;
    logic [7:0]       ch4_high;
    logic [7:0]       ch4_low;
    logic [2:0]       enable;
    logic [2:0][7:0]  in_byte;
    logic [2:0]       ibf;
    logic [2:0]       cmd_data;
    logic [2:0][7:0]  out_byte;
    logic [15:0][7:0] bidir;
    logic [7:0]       s2h_mailbox;
    logic [3:0]       irq_stat;
    logic [3:0]       irq_mask;
    logic [31:0]      prdata;
    lcad_hrsp_t       hrsp;
  } lcad_state_t;

endpackage

`default_nettype wire

// File: tb_lpc_channel_address_decode.sv
// testbench: apb master, host model and checks for the address decode
// assumes a zero-wait apb slave and a one-cycle host claim
`default_nettype none

module tb_lpc_channel_address_decode;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 irq;
  lcad_pkg::lcad_hreq_t hreq;
  lcad_pkg::lcad_hrsp_t hrsp;
  int                   bad_count = 0;
  int                   num_checks = 0;
  int                   cycles = 0;
  logic [31:0]          rd;
  logic [31:0]          rv;
  logic                 err;
  logic                 c;
  logic [7:0]           q;
  logic [7:0]           d;
  logic [2:0]           cdv;
  logic [15:0]          b [3];
  logic [7:0]           bb [16];
  logic [7:0]           zo [8];

  always #2.5 clk = ~clk;

  lcad_core dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hreq(hreq),
    .hrsp(hrsp), .irq(irq));
  lcad_host_model hm (.clk(clk), .hreq(hreq), .hrsp(hrsp));

  // ==========================================================
  // helpers
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
  endtask

  task automatic host(input logic w, input logic [15:0] a,
                      input logic [7:0] wd, input logic ec,
                      input logic [7:0] ed);
    hm.cycle(w, a, wd, c, q);
    chk({31'h0, c}, {31'h0, ec});
    if (ec && !w) chk({24'h0, q}, {24'h0, ed});
  endtask

  function automatic logic [15:0] ha(int ch, logic cd);
    ha = {b[ch][15:3], cd, b[ch][1], b[ch][0] & (ch != 1)};
  endfunction

  function automatic logic [15:0] wa(int i);
    wa = {b[1][15:5], ~b[1][4], i[3:0]};
  endfunction

  function automatic logic [7:0] sts(logic ibf, logic cd);
    sts = {4'h0, cd, 1'b0, ibf, 1'b0};
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(22));
    zo = '{lcad_pkg::OFF_CH3_HIGH, lcad_pkg::OFF_CH3_LOW,
           lcad_pkg::OFF_CH4_HIGH, lcad_pkg::OFF_CH4_LOW,
           lcad_pkg::OFF_ENABLE, lcad_pkg::OFF_CH_STATUS,
           lcad_pkg::OFF_IRQ_STAT, lcad_pkg::OFF_IRQ_MASK};
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, lcad_pkg::OFF_CH2_BASE, 32'h0);
    chk(rd, {16'h0, lcad_pkg::RST_CH2_BASE});
    foreach (zo[i]) begin
      apb(1'b0, zo[i], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, err}, 32'h1);
    // bases kept apart in the top byte so no two channels overlap
    rv = $urandom;
    b[0] = {8'h10, rv[7:3], 1'b0, rv[1:0]};
    b[1] = {8'h20, rv[15:11], 1'b0, rv[9], 1'b1};
    b[2] = {8'h30, rv[23:19], 1'b1, rv[17:16]};
    apb(1'b1, lcad_pkg::OFF_CH2_BASE, {16'h0, b[0]});
    apb(1'b1, lcad_pkg::OFF_CH3_HIGH, {24'h0, b[1][15:8]});
    apb(1'b1, lcad_pkg::OFF_CH3_LOW, {24'h0, b[1][7:0]});
    apb(1'b1, lcad_pkg::OFF_CH4_HIGH, {24'h0, b[2][15:8]});
    apb(1'b1, lcad_pkg::OFF_CH4_LOW, {24'h0, b[2][7:0]});
    apb(1'b0, lcad_pkg::OFF_CH3_LOW, 32'h0);
    chk(rd, {24'h0, b[1][7:0]});
    host(1'b1, ha(0, 1'b0), 8'h5a, 1'b0, 8'h00);
    apb(1'b1, lcad_pkg::OFF_IRQ_MASK, 32'h1);
    apb(1'b1, lcad_pkg::OFF_ENABLE, 32'h7);
    cdv = 3'h0;
    for (int ch = 0; ch < 3; ch++) begin
      d = $urandom;
      apb(1'b1, lcad_pkg::OFF_OUT_BYTE[ch], {24'h0, d});
      host(1'b0, ha(ch, 1'b0), 8'h00, 1'b1, d);
      for (int k = 0; k < 2; k++) begin
        d = $urandom;
        cdv[ch] = k[0];
        host(1'b1, ha(ch, k[0]), d, 1'b1, 8'h00);
        host(1'b0, ha(ch, 1'b1), 8'h00, 1'b1, sts(1'b1, k[0]));
        apb(1'b0, lcad_pkg::OFF_CH_STATUS, 32'h0);
        chk(rd, {25'h0, cdv, 1'b0, 3'b001 << ch});
        apb(1'b1, lcad_pkg::OFF_IN_BYTE[ch], {24'h0, ~d});
        apb(1'b0, lcad_pkg::OFF_IN_BYTE[ch], 32'h0);
        chk(rd, {24'h0, d});
        host(1'b0, ha(ch, 1'b1), 8'h00, 1'b1, sts(1'b0, k[0]));
      end
    end
    host(1'b1, ha(1, 1'b0) | 16'h1, d, 1'b0, 8'h00);
    apb(1'b0, lcad_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h7);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, lcad_pkg::OFF_IRQ_STAT, 32'h1);
    apb(1'b0, lcad_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h6);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, lcad_pkg::OFF_IRQ_STAT, 32'h6);
    for (int i = 1; i < 16; i++) begin
      bb[i] = $urandom;
      host(1'b1, wa(i), bb[i], 1'b1, 8'h00);
    end
    for (int i = 1; i < 16; i++) begin
      host(1'b0, wa(i), 8'h00, 1'b1, bb[i]);
      apb(1'b0, {lcad_pkg::BIDIR_PAGE, i[3:0], 2'b00}, 32'h0);
      chk(rd, {24'h0, bb[i]});
    end
    d = $urandom;
    apb(1'b1, {lcad_pkg::BIDIR_PAGE, 4'h5, 2'b00}, {24'h0, d});
    host(1'b0, wa(5), 8'h00, 1'b1, d);
    apb(1'b1, {lcad_pkg::BIDIR_PAGE, 4'h0, 2'b00}, {24'h0, ~d});
    host(1'b1, wa(0), d, 1'b1, 8'h00);
    host(1'b0, wa(0), 8'h00, 1'b1, ~d);
    apb(1'b0, {lcad_pkg::BIDIR_PAGE, 4'h0, 2'b00}, 32'h0);
    chk(rd, {24'h0, d});
    apb(1'b1, lcad_pkg::OFF_IRQ_MASK, 32'h8);
    apb(1'b0, lcad_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h8);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, lcad_pkg::OFF_IRQ_STAT, 32'h8);
    apb(1'b0, lcad_pkg::OFF_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, lcad_pkg::OFF_CH3_LOW, {24'h0, b[1][7:1], 1'b0});
    host(1'b0, wa(3), 8'h00, 1'b0, 8'h00);
    apb(1'b1, lcad_pkg::OFF_ENABLE, 32'h5);
    host(1'b1, ha(1, 1'b0), d, 1'b0, 8'h00);
    host(1'b1, ha(0, 1'b0), d, 1'b1, 8'h00);
    apb(1'b1, lcad_pkg::OFF_IRQ_STAT, 32'hf);
    repeat (12) begin
      rv = $urandom;
      host(rv[24], {2'b01, rv[13:0]}, rv[23:16], 1'b0, 8'h00);
    end
    apb(1'b0, lcad_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule

`default_nettype wire
